// File: hdl/dag_pkg.sv
package dag_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_PAIRS = 3;

    // ==========================================================
    // Pointer pair reset and step
    // ==========================================================
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [11:0] PTR_STEP = 12'h001;
    localparam logic [3:0] HIGH_NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ==========================================================
    // Operand decode: literal offset limit, access bank split
    // ==========================================================
    localparam logic [7:0] ILO_MAX_OFFSET = 8'h5F;
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hF;

    // ==========================================================
    // Special register map of the three pointer pairs
    // ==========================================================
    // Index 0 = first pair, 1 = second pair, 2 = third pair
    localparam logic [2:0][11:0] PLAIN_ADDR = {12'hFDF, 12'hFE7, 12'hFEF};
    localparam logic [2:0][11:0] LOW_ADDR = {12'hFD9, 12'hFE1, 12'hFE9};
    localparam logic [2:0][11:0] HIGH_ADDR = {12'hFDA, 12'hFE2, 12'hFEA};
    // Distance below the plain operand of each virtual operand
    localparam logic [11:0] OFS_PLAIN = 12'h000;
    localparam logic [11:0] OFS_INC_AFTER = 12'h001;
    localparam logic [11:0] OFS_DEC_AFTER = 12'h002;
    localparam logic [11:0] OFS_INC_FIRST = 12'h003;
    localparam logic [11:0] OFS_ADD_W = 12'h004;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_PLAIN = 3'b001,
        K_INC_AFTER = 3'b010,
        K_DEC_AFTER = 3'b011,
        K_INC_FIRST = 3'b100,
        K_ADD_W = 3'b101
    } dag_kind_e;

    typedef enum logic [1:0] {
        RS_RAM = 2'b00,
        RS_ZERO = 2'b01,
        RS_PTR = 2'b10
    } dag_rsrc_e;

endpackage : dag_pkg

// File: hdl/dag_ptr_pair.sv
`timescale 1ns/100ps

module dag_ptr_pair (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    input wire logic step_inc,
    input wire logic step_dec,
    output logic [11:0] ptr_q
);

    logic [11:0] ptr_d;

    // ==========================================================
    // Next pointer value
    // ==========================================================
    // Byte writes win over any step so a write through an own operand lands as written
    always_comb begin
        ptr_d = ptr_q;
        if (wr_lo || wr_hi) begin
            if (wr_lo) begin
                ptr_d[7:0] = wdata;
            end
            if (wr_hi) begin
                ptr_d[11:8] = wdata[3:0]; // Upper nibble of the high byte is not stored
            end
        end else if (step_inc) begin
            ptr_d = ptr_q + dag_pkg::PTR_STEP; // Whole pair, wraps in 12 bits
        end else if (step_dec) begin
            ptr_d = ptr_q - dag_pkg::PTR_STEP;
        end
    end

    // Register only
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ptr_q <= dag_pkg::PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

endmodule : dag_ptr_pair

// File: hdl/dag_addr_gen.sv
`timescale 1ns/100ps

// How it works
// - Post-decrement operand addresses current pointer, then pointer drops by one.
// - Post-increment operand addresses current pointer, then pointer rises by one.
// - Pre-increment operand raises pointer first and addresses the raised value.
// - Offset operand addresses pointer plus sign-extended working register, 80h taken as +128; nothing changes.
// - Plain operand addresses the pointer and leaves it unchanged.
// - Steps act on the whole pair, low byte carries into high byte.
// - Pointer steps never touch any arithmetic status flag.
// - Indirect read landing on a virtual operand returns zero.
// - Indirect write landing on a virtual operand does nothing.
// - Writing a pair through its own operand stores the value, no step.
// - Pointer bytes are real registers reachable by direct access.
// - Indirect access may reach every other special register.
// - Extended set leaves memory map and first two pairs' indirection unchanged.
// - Literal offset mode needs extended set, access bit 0, field up to 5Fh.
// - Literal offset mode addresses third pair plus field.
// - Access bit 1 or field 60h and up behave as without extended set.
// - Inherent and literal instructions never get redirected.
// - Access bit 0, field 60h up maps to bank 0 top or bank 15.
// - Access bit 1 forms address from bank select register and field.
// - Each pair holds a 12-bit linear address; high nibble unused.
// - Indirect addresses ignore bank select and access bit.

module dag_addr_gen (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic extended_set_enable,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] wreg,
    input wire logic req_valid,
    input wire logic req_direct,
    input wire logic req_access_bit,
    input wire logic [7:0] req_file,
    input wire logic req_write,
    input wire logic [7:0] req_wdata,
    input wire logic [7:0] ram_rdata,
    output logic [11:0] mem_addr_q,
    output logic mem_re_q,
    output logic mem_we_q,
    output logic [7:0] mem_wdata_q,
    output logic rd_valid_q,
    output logic [7:0] rd_data_q,
    output logic [11:0] first_pointer_pair,
    output logic [11:0] second_pointer_pair,
    output logic [11:0] third_pointer_pair
);

    // ==========================================================
    // Pointer pairs
    // ==========================================================
    logic [2:0][11:0] ptr;
    logic [2:0] wr_lo;
    logic [2:0] wr_hi;
    logic [2:0] step_inc;
    logic [2:0] step_dec;

    for (genvar g = 0; g < dag_pkg::NUM_PAIRS; g++) begin : g_pair
        dag_ptr_pair u_pair (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .wr_lo(wr_lo[g]),
            .wr_hi(wr_hi[g]),
            .wdata(req_wdata),
            .step_inc(step_inc[g]),
            .step_dec(step_dec[g]),
            .ptr_q(ptr[g])
        );
    end

    // Live pointer values for the core's view
    assign first_pointer_pair = ptr[0];
    assign second_pointer_pair = ptr[1];
    assign third_pointer_pair = ptr[2];

    // ==========================================================
    // Virtual operand lookup
    // ==========================================================
    function automatic logic is_virtual(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < dag_pkg::NUM_PAIRS; i++) begin
            if (addr <= dag_pkg::PLAIN_ADDR[i]
                && addr >= dag_pkg::PLAIN_ADDR[i] - dag_pkg::OFS_ADD_W) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : is_virtual

    // ==========================================================
    // Request decode and address resolution
    // ==========================================================
    logic go;
    logic ilo;
    logic [11:0] dir_addr;
    logic vhit;
    logic [1:0] vpair;
    dag_pkg::dag_kind_e vkind;
    logic [11:0] sel_ptr;
    logic [11:0] eff_addr;
    logic nullop;
    logic ptr_hit;
    logic self_wr;
    logic [7:0] ptr_byte;
    logic [11:0] mem_addr_d;
    logic mem_re_d;
    logic mem_we_d;
    logic [7:0] mem_wdata_d;
    logic acc_rd_q;
    logic acc_rd_d;
    dag_pkg::dag_rsrc_e rsrc_q;
    dag_pkg::dag_rsrc_e rsrc_d;
    logic [7:0] ptr_byte_q;
    logic [7:0] ptr_byte_d;

    // Only direct-capable instructions reach memory at all
    assign go = req_valid && req_direct;

    // Direct address: literal offset, access bank or bank-selected
    always_comb begin
        ilo = !req_access_bit && extended_set_enable
            && (req_file <= dag_pkg::ILO_MAX_OFFSET);
        if (ilo) begin
            dir_addr = ptr[2] + {dag_pkg::HIGH_NIBBLE_ZERO, req_file};
        end else if (!req_access_bit) begin
            if (req_file < dag_pkg::ACC_SPLIT) begin
                dir_addr = {dag_pkg::ACC_LOW_BANK, req_file};
            end else begin
                dir_addr = {dag_pkg::ACC_HIGH_BANK, req_file};
            end
        end else begin
            dir_addr = {bank_select_register, req_file};
        end
    end

    // Is the direct address one of the virtual operands, and which
    always_comb begin
        logic [11:0] diff;
        diff = 12'h000;
        vhit = 1'b0;
        vpair = 2'b00;
        vkind = dag_pkg::K_NONE;
        for (int i = 0; i < dag_pkg::NUM_PAIRS; i++) begin
            diff = dag_pkg::PLAIN_ADDR[i] - dir_addr;
            if (dir_addr <= dag_pkg::PLAIN_ADDR[i] && diff <= dag_pkg::OFS_ADD_W) begin
                vhit = 1'b1;
                vpair = i[1:0];
                if (diff == dag_pkg::OFS_PLAIN) begin
                    vkind = dag_pkg::K_PLAIN;
                end else if (diff == dag_pkg::OFS_INC_AFTER) begin
                    vkind = dag_pkg::K_INC_AFTER;
                end else if (diff == dag_pkg::OFS_DEC_AFTER) begin
                    vkind = dag_pkg::K_DEC_AFTER;
                end else if (diff == dag_pkg::OFS_INC_FIRST) begin
                    vkind = dag_pkg::K_INC_FIRST;
                end else begin
                    vkind = dag_pkg::K_ADD_W;
                end
            end
        end
    end

    assign sel_ptr = ptr[vpair];

    // Effective address from the pointer for virtual operands, else the direct address; W of 80h adds +128, so W spans -127..128
    always_comb begin
        case (vkind)
            dag_pkg::K_PLAIN: eff_addr = sel_ptr;
            dag_pkg::K_INC_AFTER: eff_addr = sel_ptr;
            dag_pkg::K_DEC_AFTER: eff_addr = sel_ptr;
            dag_pkg::K_INC_FIRST: eff_addr = sel_ptr + dag_pkg::PTR_STEP;
            dag_pkg::K_ADD_W: eff_addr = sel_ptr + {{4{wreg[7] & (|wreg[6:0])}}, wreg};
            default: eff_addr = dir_addr;
        endcase
    end

    // Pointer byte targets, own-pair writes and pointer side effects
    always_comb begin
        nullop = vhit && is_virtual(eff_addr);
        ptr_hit = 1'b0;
        self_wr = 1'b0;
        ptr_byte = dag_pkg::ZERO_BYTE;
        wr_lo = 3'b000;
        wr_hi = 3'b000;
        step_inc = 3'b000;
        step_dec = 3'b000;
        for (int j = 0; j < dag_pkg::NUM_PAIRS; j++) begin
            if (eff_addr == dag_pkg::LOW_ADDR[j]) begin
                ptr_hit = 1'b1;
                ptr_byte = ptr[j][7:0];
                wr_lo[j] = go && req_write;
                self_wr = self_wr || (vhit && req_write && vpair == j[1:0]);
            end
            if (eff_addr == dag_pkg::HIGH_ADDR[j]) begin
                ptr_hit = 1'b1;
                ptr_byte = {dag_pkg::HIGH_NIBBLE_ZERO, ptr[j][11:8]};
                wr_hi[j] = go && req_write;
                self_wr = self_wr || (vhit && req_write && vpair == j[1:0]);
            end
        end
        // Steps only from the stepping operands, and never on an own-pair write
        if (go && vhit && !self_wr) begin
            if (vkind == dag_pkg::K_INC_AFTER || vkind == dag_pkg::K_INC_FIRST) begin
                step_inc[vpair] = 1'b1;
            end
            if (vkind == dag_pkg::K_DEC_AFTER) begin
                step_dec[vpair] = 1'b1;
            end
        end
        // No flag output exists here, so a step cannot disturb the status bits
    end

    // Memory request and pending read source
    always_comb begin
        mem_addr_d = mem_addr_q;
        mem_re_d = 1'b0;
        mem_we_d = 1'b0;
        mem_wdata_d = mem_wdata_q;
        acc_rd_d = 1'b0;
        rsrc_d = dag_pkg::RS_RAM;
        ptr_byte_d = ptr_byte_q;
        if (go) begin
            mem_addr_d = eff_addr;
            mem_wdata_d = req_wdata;
            acc_rd_d = !req_write;
            if (nullop) begin
                rsrc_d = dag_pkg::RS_ZERO;
            end else if (ptr_hit) begin
                rsrc_d = dag_pkg::RS_PTR;
                ptr_byte_d = ptr_byte;
            end else begin
                mem_re_d = !req_write;
                mem_we_d = req_write;
            end
        end
    end

    // Register only
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mem_addr_q <= dag_pkg::PTR_RESET;
            mem_re_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_wdata_q <= dag_pkg::ZERO_BYTE;
            acc_rd_q <= 1'b0;
            rsrc_q <= dag_pkg::RS_RAM;
            ptr_byte_q <= dag_pkg::ZERO_BYTE;
        end else begin
            mem_addr_q <= mem_addr_d;
            mem_re_q <= mem_re_d;
            mem_we_q <= mem_we_d;
            mem_wdata_q <= mem_wdata_d;
            acc_rd_q <= acc_rd_d;
            rsrc_q <= rsrc_d;
            ptr_byte_q <= ptr_byte_d;
        end
    end

    // ==========================================================
    // Read return
    // ==========================================================
    logic rd_valid_d;
    logic [7:0] rd_data_d;

    // The RAM answers during the request cycle; pointer bytes and nulls bypass it
    always_comb begin
        rd_valid_d = acc_rd_q;
        rd_data_d = rd_data_q;
        if (acc_rd_q) begin
            case (rsrc_q)
                dag_pkg::RS_ZERO: rd_data_d = dag_pkg::ZERO_BYTE;
                dag_pkg::RS_PTR: rd_data_d = ptr_byte_q;
                default: rd_data_d = ram_rdata;
            endcase
        end
    end

    // Register only
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= dag_pkg::ZERO_BYTE;
        end else begin
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_dec_after;
        @(posedge clk_sys) disable iff (!resetn)
        go && vkind == dag_pkg::K_DEC_AFTER && !self_wr |=>
            mem_addr_q == $past(sel_ptr)
            && ptr[$past(vpair)] == $past(sel_ptr) - dag_pkg::PTR_STEP;
    endproperty
    a_dec_after: assert property (p_dec_after) else $error("post-decrement wrong");

    property p_inc_after;
        @(posedge clk_sys) disable iff (!resetn)
        go && vkind == dag_pkg::K_INC_AFTER && !self_wr |=>
            mem_addr_q == $past(sel_ptr)
            && ptr[$past(vpair)] == $past(sel_ptr) + dag_pkg::PTR_STEP;
    endproperty
    a_inc_after: assert property (p_inc_after) else $error("post-increment wrong");

    property p_inc_first;
        @(posedge clk_sys) disable iff (!resetn)
        go && vkind == dag_pkg::K_INC_FIRST && !self_wr |=>
            mem_addr_q == ptr[$past(vpair)]
            && mem_addr_q == $past(sel_ptr) + dag_pkg::PTR_STEP;
    endproperty
    a_inc_first: assert property (p_inc_first) else $error("pre-increment wrong");

    property p_add_w;
        @(posedge clk_sys) disable iff (!resetn)
        go && vkind == dag_pkg::K_ADD_W && !ptr_hit |=>
            mem_addr_q == $past(sel_ptr) + {{4{$past(wreg[7] & (|wreg[6:0]))}}, $past(wreg)}
            && $stable(ptr);
    endproperty
    a_add_w: assert property (p_add_w) else $error("offset operand wrong");

    property p_plain;
        @(posedge clk_sys) disable iff (!resetn)
        go && vkind == dag_pkg::K_PLAIN && !ptr_hit |=> $stable(ptr);
    endproperty
    a_plain: assert property (p_plain) else $error("plain operand moved pointer");

    property p_null_read;
        @(posedge clk_sys) disable iff (!resetn)
        go && nullop && !req_write |=> !mem_re_q ##1 rd_valid_q
            && rd_data_q == dag_pkg::ZERO_BYTE;
    endproperty
    a_null_read: assert property (p_null_read) else $error("null read not zero");

    property p_null_write;
        @(posedge clk_sys) disable iff (!resetn)
        go && nullop && req_write |=> !mem_we_q;
    endproperty
    a_null_write: assert property (p_null_write) else $error("null write reached RAM");

    property p_self_write;
        @(posedge clk_sys) disable iff (!resetn)
        go && self_wr && eff_addr == dag_pkg::LOW_ADDR[vpair] |=>
            ptr[$past(vpair)][7:0] == $past(req_wdata)
            && ptr[$past(vpair)][11:8] == $past(sel_ptr[11:8]);
    endproperty
    a_self_write: assert property (p_self_write) else $error("own pair write stepped");

    property p_ilo;
        @(posedge clk_sys) disable iff (!resetn)
        go && extended_set_enable && !req_access_bit && req_file <= dag_pkg::ILO_MAX_OFFSET
            && !vhit |=>
            mem_addr_q == $past(ptr[2]) + {dag_pkg::HIGH_NIBBLE_ZERO, $past(req_file)};
    endproperty
    a_ilo: assert property (p_ilo) else $error("literal offset address wrong");

    property p_long;
        @(posedge clk_sys) disable iff (!resetn)
        go && req_access_bit && !vhit |=>
            mem_addr_q == {$past(bank_select_register), $past(req_file)};
    endproperty
    a_long: assert property (p_long) else $error("bank-selected address wrong");

endmodule : dag_addr_gen

// File: testbench/dag_ram_model.sv
`timescale 1ns/100ps

module dag_ram_model (
    input wire logic clk_sys,
    input wire logic [11:0] mem_addr_q,
    input wire logic mem_re_q,
    input wire logic mem_we_q,
    input wire logic [7:0] mem_wdata_q,
    output logic [7:0] ram_rdata
);
    // ==========================================================
    // Storage with a known fill pattern
    // ==========================================================
    logic [7:0] mem [0:4095];
    logic [7:0] last_q;

    // Fill pattern differs from the address so stale data shows up
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
        last_q = 8'h00;
    end

    // Writes land on the strobe edge; last read kept for the idle value
    always @(posedge clk_sys) begin
        if (mem_we_q) begin
            mem[mem_addr_q] <= mem_wdata_q;
        end
        if (mem_re_q) begin
            last_q <= mem[mem_addr_q];
        end
    end

    // Idle bus shows inverted data so a late sample cannot pass by luck
    assign ram_rdata = mem_re_q ? mem[mem_addr_q] : ~last_q;
endmodule : dag_ram_model

// File: testbench/data_address_generator_test.sv
`timescale 1ns/100ps

module data_address_generator_test;
    logic clk_sys, resetn, ext_en, req_valid, req_direct, req_a, req_write;
    logic [3:0] bank_sel;
    logic [7:0] wreg, req_file, req_wdata, ram_rdata, mem_wdata_q, rd_data_q;
    logic [11:0] mem_addr_q, ptr0, ptr1, ptr2;
    logic mem_re_q, mem_we_q, rd_valid_q;
    logic [11:0] g_addr;
    logic g_re, g_we, g_rv;
    logic [7:0] g_wd, g_rd;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;

    dag_addr_gen u_dut (.clk_sys(clk_sys), .resetn(resetn), .extended_set_enable(ext_en),
        .bank_select_register(bank_sel), .wreg(wreg), .req_valid(req_valid),
        .req_direct(req_direct), .req_access_bit(req_a), .req_file(req_file),
        .req_write(req_write), .req_wdata(req_wdata), .ram_rdata(ram_rdata),
        .mem_addr_q(mem_addr_q), .mem_re_q(mem_re_q), .mem_we_q(mem_we_q),
        .mem_wdata_q(mem_wdata_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
        .first_pointer_pair(ptr0), .second_pointer_pair(ptr1), .third_pointer_pair(ptr2));

    dag_ram_model u_ram (.clk_sys(clk_sys), .mem_addr_q(mem_addr_q), .mem_re_q(mem_re_q),
        .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .ram_rdata(ram_rdata));

    // ==========================================================
    // Clock and hang guard
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Whole run is under 100 cycles; ceiling leaves ample margin
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ==========================================================
    // Compare and access tasks
    // ==========================================================
    task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_addr

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_addr({4'h0, got}, {4'h0, exp});
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        chk_addr({11'h000, got}, {11'h000, exp});
    endtask : chk_bit

    function automatic logic [7:0] fill(input logic [11:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction : fill

    // Called at a falling edge; captures answer cycles c1 and c2
    task automatic xfer(input logic wr, input logic a, input logic [7:0] f,
                        input logic [7:0] wd, input logic dir);
        req_valid = 1'b1;
        req_direct = dir;
        req_write = wr;
        req_a = a;
        req_file = f;
        req_wdata = wd;
        @(negedge clk_sys);
        g_addr = mem_addr_q;
        g_re = mem_re_q;
        g_we = mem_we_q;
        g_wd = mem_wdata_q;
        req_valid = 1'b0;
        @(negedge clk_sys);
        g_rv = rd_valid_q;
        g_rd = rd_data_q;
    endtask : xfer

    // Pointer bytes reached by bank-selected direct access
    task automatic set_ptr(input int n, input logic [11:0] v);
        bank_sel = 4'hF;
        xfer(1'b1, 1'b1, dag_pkg::LOW_ADDR[n][7:0], v[7:0], 1'b1);
        xfer(1'b1, 1'b1, dag_pkg::HIGH_ADDR[n][7:0], {4'h0, v[11:8]}, 1'b1);
    endtask : set_ptr

    // Indirect operand through the access bank upper half
    task automatic ind(input int n, input logic [11:0] ofs, input logic wr, input logic [7:0] wd);
        logic [11:0] op;
        op = dag_pkg::PLAIN_ADDR[n] - ofs;
        xfer(wr, 1'b0, op[7:0], wd, 1'b1);
    endtask : ind

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Test sequence
    // ==========================================================
    logic [3:0] t_bank [5] = '{4'h0, 4'h0, 4'h0, 4'h5, 4'h0};
    logic [7:0] t_f [5] = '{8'h5F, 8'h60, 8'hFF, 8'h10, 8'h10};
    logic t_ext [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic t_a [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [11:0] t_exp [5] = '{12'h04F, 12'h060, 12'hFFF, 12'h510, 12'h010};

    initial begin
        resetn = 1'b0;
        ext_en = 1'b0;
        bank_sel = 4'h0;
        wreg = 8'h00;
        req_valid = 1'b0;
        req_direct = 1'b0;
        req_a = 1'b0;
        req_write = 1'b0;
        req_file = 8'h00;
        req_wdata = 8'h00;
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        chk_addr(ptr0 | ptr1 | ptr2, 12'h000);
        chk_bit(mem_re_q | mem_we_q | rd_valid_q, 1'b0);
        $display("test reset done");

        // Pointer bytes: direct write, no RAM strobe, high nibble dropped
        bank_sel = 4'hF;
        xfer(1'b1, 1'b1, dag_pkg::LOW_ADDR[2][7:0], 8'hFF, 1'b1);
        chk_bit(g_we, 1'b0);
        xfer(1'b1, 1'b1, dag_pkg::HIGH_ADDR[2][7:0], 8'hF1, 1'b1);
        chk_addr(ptr2, 12'h1FF);
        xfer(1'b0, 1'b1, dag_pkg::HIGH_ADDR[2][7:0], 8'h00, 1'b1);
        chk_byte(g_rd, 8'h01);
        $display("test pointer bytes done");

        // Stepping, plain and offset operands with the extended set on, bank select elsewhere
        ext_en = 1'b1;
        set_ptr(0, 12'h0FF);
        bank_sel = 4'h3;
        ind(0, dag_pkg::OFS_INC_AFTER, 1'b0, 8'h00);
        chk_addr(g_addr, 12'h0FF);
        chk_byte(g_rd, fill(12'h0FF));
        chk_addr(ptr0, 12'h100);
        ind(0, dag_pkg::OFS_DEC_AFTER, 1'b0, 8'h00);
        chk_addr(g_addr, 12'h100);
        chk_addr(ptr0, 12'h0FF);
        ind(0, dag_pkg::OFS_INC_FIRST, 1'b0, 8'h00);
        chk_addr(g_addr, 12'h100);
        chk_addr(ptr0, 12'h100);
        ind(0, dag_pkg::OFS_PLAIN, 1'b1, 8'hA5);
        chk_addr({g_we, g_wd, 3'h0}, {1'b1, 8'hA5, 3'h0});
        ind(0, dag_pkg::OFS_PLAIN, 1'b0, 8'h00);
        chk_byte(g_rd, 8'hA5);
        chk_addr(ptr0, 12'h100);
        wreg = 8'hFF;
        ind(0, dag_pkg::OFS_ADD_W, 1'b0, 8'h00);
        chk_addr(g_addr, 12'h0FF);
        wreg = 8'h80;
        ind(0, dag_pkg::OFS_ADD_W, 1'b0, 8'h00);
        chk_addr(g_addr, 12'h180);
        wreg = 8'h81;
        ind(0, dag_pkg::OFS_ADD_W, 1'b0, 8'h00);
        chk_addr(g_addr, 12'h081);
        chk_addr(ptr0, 12'h100);
        set_ptr(1, 12'hFFF);
        ind(1, dag_pkg::OFS_INC_AFTER, 1'b0, 8'h00);
        chk_addr({g_addr, ptr1}, {12'hFFF, 12'h000});
        $display("test stepping done");

        // Pointer aimed at a virtual operand or at pointer bytes
        set_ptr(0, 12'hFE7);
        ind(0, dag_pkg::OFS_PLAIN, 1'b0, 8'h00);
        chk_addr({g_rv, g_rd}, {1'b1, 8'h00});
        ind(0, dag_pkg::OFS_PLAIN, 1'b1, 8'h77);
        chk_bit(g_we, 1'b0);
        set_ptr(1, dag_pkg::LOW_ADDR[0]);
        ind(1, dag_pkg::OFS_PLAIN, 1'b1, 8'h22);
        chk_addr(ptr0, 12'hF22);
        set_ptr(2, dag_pkg::LOW_ADDR[2]);
        ind(2, dag_pkg::OFS_DEC_AFTER, 1'b1, 8'h34);
        chk_addr(ptr2, 12'hF34);
        chk_bit(g_we, 1'b0);
        $display("test virtual targets done");

        // Direct forms: literal offset window, access bank, bank select
        set_ptr(2, 12'hFF0);
        for (int i = 0; i < 5; i++) begin
            ext_en = t_ext[i];
            bank_sel = t_bank[i];
            xfer(1'b0, t_a[i], t_f[i], 8'h00, 1'b1);
            chk_addr(g_addr, t_exp[i]);
            chk_byte(g_rd, fill(t_exp[i]));
        end
        ext_en = 1'b1;
        xfer(1'b0, 1'b0, 8'h10, 8'h00, 1'b0);
        chk_addr({g_re, g_addr}, {1'b0, 12'h010});
        $display("test direct forms done");
        print_verdict();
    end
endmodule : data_address_generator_test
